// File: src/irq_trap_pkg.sv
/*
  Shared constants for the interrupt and trap controller: register offsets,
  reset values, interrupt level assignment and vector layout.
  Assumes a single system clock and the 16-bit constant data bus.
*/
package irq_trap_pkg;

  // sizes
  localparam int NUM_IRQ = 8;
  localparam int LVL_W   = 3;
  localparam int DATA_W  = 16;
  localparam int ADDR_W  = 3;
  localparam int BASE_W  = 8;
  localparam int VEC_W   = 12;

  // register offsets on the control pipeline port
  localparam logic [ADDR_W-1:0] ADDR_REQUEST = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_MASK    = 3'h1;
  localparam logic [ADDR_W-1:0] ADDR_INSERV  = 3'h2;
  localparam logic [ADDR_W-1:0] ADDR_BASE    = 3'h3;
  localparam logic [ADDR_W-1:0] ADDR_STATUS  = 3'h4;

  // reset values
  localparam logic [NUM_IRQ-1:0] REQUEST_RST = 8'h00;
  localparam logic [NUM_IRQ-1:0] MASK_RST    = 8'h00;
  localparam logic [NUM_IRQ-1:0] INSERV_RST  = 8'h00;
  localparam logic [BASE_W-1:0]  BASE_RST    = 8'h00;

  // interrupt levels, higher number wins
  localparam logic [LVL_W-1:0] LVL_DBUS_PARITY = 3'h7;
  localparam logic [LVL_W-1:0] LVL_MULT_PARITY = 3'h6;
  localparam logic [LVL_W-1:0] LVL_ALU_PARITY  = 3'h5;
  localparam logic [LVL_W-1:0] LVL_FLOAT       = 3'h4;
  localparam logic [LVL_W-1:0] LVL_STACK       = 3'h3;
  localparam logic [LVL_W-1:0] LVL_HOST        = 3'h2;
  localparam logic [LVL_W-1:0] LVL_SOFT1       = 3'h1;
  localparam logic [LVL_W-1:0] LVL_SOFT0       = 3'h0;

  // vector layout: base | trap flag | level
  localparam int VEC_TRAP_BIT = 3;
  localparam int VEC_BASE_LSB = 4;

  // status register bit positions
  localparam int STAT_MREQ_BIT = 4;
  localparam int STAT_IRQ_BIT  = 5;
  localparam int STAT_TRAP_BIT = 6;

endpackage

// File: src/request_bit.sv
/*
  One latched interrupt request bit.
  Assumes set, write and clear come from logic on the same clock.
*/
`timescale 1ns/1ps
module request_bit (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  // controls
  input  wire logic set,
  input  wire logic wr_en,
  input  wire logic wr_val,
  input  wire logic clr,
  // state
  output logic      q
);

  // a source event wins over a software write and over the acknowledge clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= 1'b0;
    end else if (ce) begin
      if (set) begin
        q <= 1'b1;
      end else if (wr_en) begin
        q <= wr_val;
      end else if (clr) begin
        q <= 1'b0;
      end
    end
  end

endmodule

// File: src/irq_trap_ctrl.sv
/*
  Interrupt and trap controller for a microprogrammed processor: eight
  latched, masked, prioritised requests, a breakpoint trap path and the
  vector driven onto the control-store address on acknowledge.
  Assumes the sequencer answers its request with an active-low acknowledge
  on the same clock, and the control pipeline drives the register port.
*/
// Decided for this implementation: the register addresses and the plain strobed port.
`timescale 1ns/1ps
module irq_trap_ctrl
  import irq_trap_pkg::*;
(
  // clock, reset, clock enable
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              ce,
  // hardware interrupt sources, active low, same clock
  input  wire logic              dbus_parity_err_n,
  input  wire logic              mult_parity_err_n,
  input  wire logic              alu_parity_err_n,
  input  wire logic              stack_nearly_full_n,
  // float unit status flags, active high, same clock
  input  wire logic              float_unit_overflow,
  input  wire logic              float_unit_underflow,
  input  wire logic              float_unit_invalid,
  // host bus interrupt, active low, asynchronous
  input  wire logic              host_irq_n,
  // control pipeline register port
  input  wire logic              ic_select,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  input  wire logic              pipe_force_continue,
  // sequencer
  input  wire logic              breakpoint_match,
  input  wire logic              sequencer_acknowledge_n,
  output logic                   sequencer_irq_in_n,
  output logic      [VEC_W-1:0]  vec_out,
  output logic                   vec_oe_n,
  output logic                   force_continue,
  output logic                   carry_in_n,
  output logic                   trap_abort,
  output logic                   cascade_block_out,
  output logic                   masked_request_out_n
);

  // state
  logic               host_meta;
  logic               host_sync;
  logic [NUM_IRQ-1:0] request;
  logic [NUM_IRQ-1:0] mask;
  logic [NUM_IRQ-1:0] in_service;
  logic [BASE_W-1:0]  base;
  logic               masked_req;
  logic [LVL_W-1:0]   lvl_q;
  logic               irq_ff;
  logic               trap_req;

  // highest set bit of a request vector
  function automatic logic [LVL_W-1:0] top_level(input logic [NUM_IRQ-1:0] v);
    logic [LVL_W-1:0] r;
    r = LVL_SOFT0;
    for (int i = 0; i < NUM_IRQ; i++) begin
      if (v[i]) begin
        r = LVL_W'(i);
      end
    end
    return r;
  endfunction

  // host line crosses in through two flip-flops
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      host_meta <= 1'b1;
      host_sync <= 1'b1;
    end else if (ce) begin
      host_meta <= host_irq_n;
      host_sync <= host_meta;
    end
  end

  // source map: parity on the top three levels, float, stack, host, software
  wire float_any = float_unit_overflow | float_unit_underflow
                 | float_unit_invalid;
  wire [NUM_IRQ-1:0] src_active;
  assign src_active[LVL_DBUS_PARITY] = ~dbus_parity_err_n;
  assign src_active[LVL_MULT_PARITY] = ~mult_parity_err_n;
  assign src_active[LVL_ALU_PARITY]  = ~alu_parity_err_n;
  assign src_active[LVL_FLOAT]       = float_any;
  assign src_active[LVL_STACK]       = ~stack_nearly_full_n;
  assign src_active[LVL_HOST]        = ~host_sync;
  assign src_active[LVL_SOFT1]       = 1'b0;
  assign src_active[LVL_SOFT0]       = 1'b0;

  // register port decode, select and strobes from the pipeline
  wire wr_hit  = ic_select & reg_wr;
  wire rd_hit  = ic_select & reg_rd;
  wire wr_req  = wr_hit & (reg_addr == ADDR_REQUEST);
  wire wr_mask = wr_hit & (reg_addr == ADDR_MASK);
  wire wr_isr  = wr_hit & (reg_addr == ADDR_INSERV);
  wire wr_base = wr_hit & (reg_addr == ADDR_BASE);

  // acknowledge decode: a trap outranks any interrupt in the same cycle
  wire ack     = ~sequencer_acknowledge_n;
  wire ack_int = ack & irq_ff & ~trap_req;

  // one held request bit per level
  genvar g;
  generate
    for (g = 0; g < NUM_IRQ; g++) begin : g_req
      request_bit u_bit (
        .clk    (clk),
        .rst    (rst),
        .ce     (ce),
        .set    (src_active[g]),
        .wr_en  (wr_req),
        .wr_val (reg_wdata[g]),
        .clr    (ack_int && (lvl_q == LVL_W'(g))),
        .q      (request[g])
      );
    end
  endgenerate

  // masking and priority against the in-service level
  wire [NUM_IRQ-1:0] pend    = request & mask;
  wire [LVL_W-1:0]   pend_lvl = top_level(pend);
  wire [LVL_W-1:0]   isr_lvl  = top_level(in_service);
  wire               allowed  = (|pend)
                              && (!(|in_service) || (pend_lvl > isr_lvl));

  // mask, in-service and base registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mask       <= MASK_RST;
      in_service <= INSERV_RST;
      base       <= BASE_RST;
    end else if (ce) begin
      if (wr_mask) begin
        mask <= reg_wdata[NUM_IRQ-1:0];
      end
      if (ack_int) begin
        in_service[lvl_q] <= 1'b1;
      end else if (wr_isr) begin
        in_service <= reg_wdata[NUM_IRQ-1:0];
      end
      if (wr_base) begin
        base <= reg_wdata[BASE_W-1:0];
      end
    end
  end

  // masked request and its level, blocked while a trap cascades
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      masked_req <= 1'b0;
      lvl_q      <= LVL_SOFT0;
    end else if (ce) begin
      masked_req <= allowed & ~cascade_block_out & ~ack_int;
      lvl_q      <= ack_int ? lvl_q : pend_lvl;
    end
  end

  // delay flip-flop towards the sequencer; it drops on acknowledge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_ff <= 1'b0;
    end else if (ce) begin
      irq_ff <= masked_req & ~ack_int;
    end
  end

  // breakpoint seen at fetch becomes a trap in the following cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      trap_req <= 1'b0;
    end else if (ce) begin
      trap_req <= breakpoint_match;
    end
  end

  // read data, standing in the cycle after the read strobe
  wire [DATA_W-1:0] status_word = DATA_W'({trap_req, irq_ff, masked_req,
                                           1'b0, lvl_q});
  wire [DATA_W-1:0] rd_mux =
      (reg_addr == ADDR_REQUEST) ? DATA_W'(request)    :
      (reg_addr == ADDR_MASK)    ? DATA_W'(mask)       :
      (reg_addr == ADDR_INSERV)  ? DATA_W'(in_service) :
      (reg_addr == ADDR_BASE)    ? DATA_W'(base)       :
      (reg_addr == ADDR_STATUS)  ? status_word         : 16'h0000;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
    end else if (ce) begin
      reg_rdata <= rd_hit ? rd_mux : 16'h0000;
    end
  end

  // sequencer request: registered interrupt ORed with the registered trap
  assign sequencer_irq_in_n   = ~(irq_ff | trap_req);
  assign masked_request_out_n = ~masked_req;

  // trap side: freeze the sequencer, hold the address, abort the cycle
  assign force_continue    = trap_req | pipe_force_continue;
  assign carry_in_n        = trap_req | rst;
  assign trap_abort        = trap_req;
  assign cascade_block_out = trap_req;

  // vector gated onto the control-store address by the acknowledge
  assign vec_oe_n = sequencer_acknowledge_n;
  assign vec_out  = {base, trap_req,
                     trap_req ? LVL_SOFT0 : lvl_q};

  // checks
  sequence s_mreq;
    ce && masked_req && !ack_int;
  endsequence

  sequence s_trap;
    ce && breakpoint_match;
  endsequence

  AST_STACK_LATCH: assert property (@(posedge clk) disable iff (rst)
    ce && !stack_nearly_full_n |=> request[LVL_STACK])
    else $error("stack nearly full not latched");

  AST_STACK_BELOW_FLOAT: assert property (@(posedge clk) disable iff (rst)
    pend[LVL_FLOAT] && pend[LVL_STACK] && !(|pend[NUM_IRQ-1:5])
      |-> pend_lvl == LVL_FLOAT)
    else $error("stack level outranked float level");

  AST_TRAP_EVENT: assert property (@(posedge clk) disable iff (rst)
    s_trap |=> trap_req && !sequencer_irq_in_n && cascade_block_out)
    else $error("breakpoint did not trap in next cycle");

  AST_VEC_ON_ACK: assert property (@(posedge clk) disable iff (rst)
    !sequencer_acknowledge_n |-> !vec_oe_n
      && vec_out[VEC_W-1:VEC_BASE_LSB] == base)
    else $error("vector not driven on acknowledge");

  AST_TRAP_FREEZE: assert property (@(posedge clk) disable iff (rst)
    trap_req |-> force_continue && carry_in_n && trap_abort)
    else $error("trap did not freeze state");

  AST_VEC_TRAP_BIT: assert property (@(posedge clk) disable iff (rst)
    !sequencer_acknowledge_n |-> vec_out[VEC_TRAP_BIT] == trap_req)
    else $error("vector trap bit wrong");

  AST_CASCADE: assert property (@(posedge clk) disable iff (rst)
    ce && cascade_block_out |=> !$rose(masked_req))
    else $error("interrupt started during trap");

  AST_SOFT_WRITE: assert property (@(posedge clk) disable iff (rst)
    ce && wr_req && reg_wdata[LVL_SOFT0] |=> request[LVL_SOFT0])
    else $error("software interrupt not raised");

  AST_HOLD: assert property (@(posedge clk) disable iff (rst)
    ce && request[LVL_HOST] && !wr_req && !(ack_int && lvl_q == LVL_HOST)
      |=> request[LVL_HOST])
    else $error("held request dropped");

  AST_MASKED_OFF: assert property (@(posedge clk) disable iff (rst)
    ce && pend == 8'h00 |=> !masked_req ##1 !irq_ff)
    else $error("request raised with nothing pending");

  AST_IRQ_CHAIN: assert property (@(posedge clk) disable iff (rst)
    s_mreq |=> irq_ff && !sequencer_irq_in_n)
    else $error("masked request did not reach sequencer");

  // acknowledge, host line and register port checks
  // an interrupt taken by the sequencer
  sequence s_ack;
    ce && ack_int;
  endsequence

  // host line low, then two synchroniser edges
  sequence s_host_low;
    ce && !host_irq_n ##1 ce ##1 ce;
  endsequence

  AST_PARITY_NO_TRAP: assert property (@(posedge clk) disable iff (rst)
    ce && !breakpoint_match
      && !(dbus_parity_err_n && mult_parity_err_n && alu_parity_err_n)
      |=> !trap_req && (|request[NUM_IRQ-1:LVL_ALU_PARITY]))
    else $error("parity error took the trap path");

  AST_ACK_TAKES: assert property (@(posedge clk) disable iff (rst)
    s_ack
      |=> in_service[$past(lvl_q)] && !masked_req && !irq_ff)
    else $error("acknowledge did not take the request");

  AST_ACK_CLEAR: assert property (@(posedge clk) disable iff (rst)
    ce && ack_int && !src_active[lvl_q] && !wr_req
      |=> !request[$past(lvl_q)])
    else $error("acknowledged request still held");

  AST_LOWER_WAITS: assert property (@(posedge clk) disable iff (rst)
    ce && (|in_service) && (pend_lvl <= isr_lvl)
      |=> !masked_req)
    else $error("request raised below in-service level");

  AST_HOST_SYNC: assert property (@(posedge clk) disable iff (rst)
    s_host_low
      |=> request[LVL_HOST])
    else $error("host request not latched after synchroniser");

  AST_TRAP_VEC_LVL: assert property (@(posedge clk) disable iff (rst)
    trap_req
      |-> vec_out[VEC_TRAP_BIT] && vec_out[LVL_W-1:0] == LVL_SOFT0)
    else $error("trap vector level bits not zero");

  AST_TRAP_NO_ACK: assert property (@(posedge clk) disable iff (rst)
    ce && trap_req && !sequencer_acknowledge_n && !wr_isr
      |=> in_service == $past(in_service))
    else $error("interrupt taken during trap");

  AST_RDATA_IDLE: assert property (@(posedge clk) disable iff (rst)
    ce && !rd_hit
      |=> reg_rdata == 16'h0000)
    else $error("read data not idle without a read");

endmodule

// File: tb/seq_model.sv
/*
  Behavioural sequencer partner: answers interrupt and trap requests with
  an active-low acknowledge and records every vector that it takes.
  Assumes the controller's outputs change only just after rising edges.
*/
`timescale 1ns/1ps
module seq_model
  import irq_trap_pkg::*;
(
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // controller side
  input  wire logic             sequencer_irq_in_n,
  input  wire logic             trap_abort,
  input  wire logic [VEC_W-1:0] vec_out,
  output logic                  sequencer_acknowledge_n,
  // test controls and record
  input  wire logic [3:0]       ack_wait,
  output logic      [VEC_W-1:0] last_vec,
  output int                    n_ack
);
  logic [3:0] waited;

  // a trap must be taken in its own cycle, an interrupt after ack_wait cycles
  assign sequencer_acknowledge_n = ~(trap_abort | (~sequencer_irq_in_n & (waited >= ack_wait)));

  // count the wait and record the vector taken at each acknowledge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      waited   <= 4'h0;
      last_vec <= '0;
      n_ack    <= 0;
    end else if (!sequencer_acknowledge_n) begin
      waited   <= 4'h0;
      last_vec <= vec_out;
      n_ack    <= n_ack + 1;
    end else if (!sequencer_irq_in_n) begin
      waited <= waited + 4'h1;
    end else begin
      waited <= 4'h0;
    end
  end
endmodule

// File: tb/tb.sv
/*
  Self-checking bench for the interrupt and trap controller.
  Assumes the sequencer model answers requests and records vectors.
*/
`timescale 1ns/1ps
module tb;
  import irq_trap_pkg::*;
  logic clk, rst, ce, ic_select, reg_wr, reg_rd, breakpoint_match, pipe_force_continue;
  logic sequencer_irq_in_n, sequencer_acknowledge_n, vec_oe_n, force_continue;
  logic carry_in_n, trap_abort, cascade_block_out, masked_request_out_n;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata, rd_data;
  logic [VEC_W-1:0]  vec_out, last_vec;
  logic [7:0]        ev; // one bit per hardware event, active high
  logic [3:0]        ack_wait;
  logic [LVL_W-1:0]  exp_lvl [8];
  logic [BASE_W-1:0] base;
  int                n_ack, n0, n_fail, comparisons;

  irq_trap_ctrl irq_trap_ctrl_inst (.clk, .rst, .ce, .dbus_parity_err_n(~ev[0]),
    .mult_parity_err_n(~ev[1]), .alu_parity_err_n(~ev[2]), .float_unit_overflow(ev[3]),
    .float_unit_underflow(ev[4]), .float_unit_invalid(ev[5]),
    .stack_nearly_full_n(~ev[6]), .host_irq_n(~ev[7]), .ic_select, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .pipe_force_continue, .breakpoint_match,
    .sequencer_acknowledge_n, .sequencer_irq_in_n, .vec_out, .vec_oe_n, .force_continue,
    .carry_in_n, .trap_abort, .cascade_block_out, .masked_request_out_n);
  seq_model seq_model_inst (.clk, .rst, .sequencer_irq_in_n, .trap_abort, .vec_out,
    .sequencer_acknowledge_n, .ack_wait, .last_vec, .n_ack);

  // clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [15:0] d, input logic sel = 1'b1);
    @(posedge clk);
    ic_select <= sel;
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    ic_select <= 1'b0;
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a);
    @(posedge clk);
    ic_select <= 1'b1;
    reg_rd    <= 1'b1;
    reg_addr  <= a;
    @(posedge clk);
    ic_select <= 1'b0;
    reg_rd    <= 1'b0;
    #1 rd_data = reg_rdata;
  endtask

  // one-cycle event; returns at the edge that latches it
  task automatic pulse(input int i);
    @(posedge clk);
    ev[i] <= 1'b1;
    @(posedge clk);
    ev[i] <= 1'b0;
  endtask

  task automatic wait_ack(input logic [VEC_W-1:0] exp);
    int k;
    k = 0;
    while (n_ack == n0 && k < 40) begin
      @(posedge clk);
      #1 k++;
    end
    check(16'(n_ack - n0), 16'h0001);
    check(16'(last_vec), 16'(exp));
    n0 = n_ack;
  endtask

  task automatic t_regs();
    for (int a = 0; a < 4; a++) begin
      rd(3'(a));
      check(rd_data, 16'h0000);
    end
    wr(ADDR_MASK, 16'h00FF);
    rd(ADDR_MASK);
    check(rd_data, 16'h00FF);
    wr(ADDR_BASE, 16'h00A5);
    wr(ADDR_BASE, 16'h00FF, 1'b0);
    ce <= 1'b0;
    wr(ADDR_BASE, 16'h005A);
    ce <= 1'b1;
    rd(ADDR_BASE);
    check(rd_data, 16'h00A5);
    wr(3'h5, 16'h00FF);
    rd(3'h5);
    check(rd_data, 16'h0000);
    base = 8'hA5;
  endtask

  // every hardware source gives its mapped level (the three float flags share LVL_FLOAT), never a trap vector
  task automatic t_sources();
    for (int i = 0; i < 8; i++) begin
      pulse(i);
      wait_ack({base, 1'b0, exp_lvl[i]});
      rd(ADDR_INSERV);
      check(rd_data, 16'(1 << exp_lvl[i]));
      rd(ADDR_REQUEST);
      check(rd_data, 16'h0000);
      wr(ADDR_INSERV, 16'h0000);
    end
  endtask

  task automatic t_timing();
    ack_wait <= 4'h3;
    pulse(2);
    #1 check(16'(masked_request_out_n), 16'h0001);
    @(posedge clk);
    #1 check(16'({masked_request_out_n, sequencer_irq_in_n}), 16'h0001);
    @(posedge clk);
    #1 check(16'(sequencer_irq_in_n), 16'h0000);
    wait_ack({base, 1'b0, LVL_ALU_PARITY});
    wr(ADDR_INSERV, 16'h0000);
    ack_wait <= 4'h0;
  endtask

  // a lower level waits behind in-service, a masked one stays latched
  task automatic t_prio_mask();
    pulse(0);
    wait_ack({base, 1'b0, LVL_DBUS_PARITY});
    pulse(2);
    repeat (4) @(posedge clk);
    #1 check(16'(n_ack - n0), 16'h0000);
    wr(ADDR_INSERV, 16'h0000);
    wait_ack({base, 1'b0, LVL_ALU_PARITY});
    wr(ADDR_INSERV, 16'h0000);
    wr(ADDR_MASK, 16'h00F7);
    pulse(6);
    rd(ADDR_REQUEST);
    check(rd_data, 16'h0008);
    check(16'(masked_request_out_n), 16'h0001);
    wr(ADDR_MASK, 16'h00FF);
    wait_ack({base, 1'b0, LVL_STACK});
    wr(ADDR_INSERV, 16'h0000);
    wr(ADDR_MASK, 16'h0000);
    pulse(6);
    pulse(3);
    wr(ADDR_MASK, 16'h00FF);
    wait_ack({base, 1'b0, LVL_FLOAT});
    wr(ADDR_INSERV, 16'h0000);
    wait_ack({base, 1'b0, LVL_STACK});
    wr(ADDR_INSERV, 16'h0000);
  endtask

  task automatic t_soft();
    for (int s = 1; s >= 0; s--) begin
      wr(ADDR_REQUEST, 16'(1 << s));
      wait_ack({base, 1'b0, 3'(s)});
      wr(ADDR_INSERV, 16'h0000);
    end
  endtask

  task automatic t_trap();
    @(posedge clk);
    pipe_force_continue <= 1'b1;
    @(posedge clk);
    #1 check(16'({force_continue, trap_abort, carry_in_n}), 16'h0004);
    @(posedge clk);
    pipe_force_continue <= 1'b0;
    breakpoint_match <= 1'b1;
    #1 check(16'(trap_abort), 16'h0000);
    @(posedge clk);
    breakpoint_match <= 1'b0;
    #1 check(16'({trap_abort, force_continue, carry_in_n, cascade_block_out,
                  sequencer_irq_in_n, vec_oe_n}), 16'h003C);
    check(16'(vec_out), 16'({base, 4'h8}));
    @(posedge clk);
    #1 check(16'(n_ack - n0), 16'h0001);
    check(16'(trap_abort), 16'h0000);
    check(16'(last_vec), 16'({base, 4'h8}));
    rd(ADDR_INSERV);
    check(rd_data, 16'h0000);
  endtask

  task automatic end_of_test();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // main sequence
  initial begin
    {ce, rst, ic_select, reg_wr, reg_rd, breakpoint_match, pipe_force_continue} = 7'h60;
    {reg_addr, reg_wdata, ev, ack_wait, base} = '0;
    exp_lvl = '{LVL_DBUS_PARITY, LVL_MULT_PARITY, LVL_ALU_PARITY, LVL_FLOAT, LVL_FLOAT,
                LVL_FLOAT, LVL_STACK, LVL_HOST};
    repeat (8) @(posedge clk);
    #1 check(16'({carry_in_n, sequencer_irq_in_n, masked_request_out_n}), 16'h0007);
    @(posedge clk);
    rst <= 1'b0;
    n0 = 0;
    t_regs();
    t_sources();
    t_timing();
    t_prio_mask();
    t_soft();
    t_trap();
    end_of_test();
  end

  // watchdog
  initial begin
    #200000;
    n_fail++;
    end_of_test();
  end
endmodule
